// File: hw/dsq_seq.sv
// Holds: delta-sigma ADC sequencer, decimator and result path
// Assumes: modulator bit stream synchronous to CLK, start pin asynchronous
`timescale 1ns/1ps
`default_nettype none
module dsq_seq #(
	parameter int OSR_HI = dsq_pkg::DSQ_OSR_12,
	parameter int OSR_LO = dsq_pkg::DSQ_OSR_8
)(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// Control
	input  wire logic [1:0]  MODE,
	input  wire logic        LOW_RES,
	input  wire logic        START_BIT,
	input  wire logic        STOP,
	input  wire logic        SOC_PIN,
	// Modulator stream
	input  wire logic        MOD_BIT,
	// Result read side
	input  wire logic        RESULT_READ,
	output logic [15:0]      RESULT,
	output logic             RESULT_VALID,
	// Status
	output logic             EOC,
	output logic             DONE_STATUS,
	output logic             BUSY
);
	////////////////////////////////////////////////////////////////////////
	dsq_pkg::dsq_state_e st_q, st_d;
	dsq_pkg::dsq_mode_e  mode_q, mode_d;
	logic [1:0]  sync_q;
	logic        soc_old_q;
	logic        start_ev;
	logic [7:0]  tick_q, tick_d;
	logic [7:0]  acc_q [dsq_pkg::DSQ_TAPS];
	logic [7:0]  acc_d [dsq_pkg::DSQ_TAPS];
	logic [1:0]  prime_q, prime_d;
	logic        conv_end;
	logic [9:0]  sum;
	logic        push;
	logic        f_ready, f_valid;
	dsq_pkg::dsq_result_s f_in, f_out;
	logic        eoc_q, eoc_d;
	logic        busy_q;

	function automatic logic [7:0] osr_of(input logic low);
		osr_of = low ? 8'(OSR_LO) : 8'(OSR_HI);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Start sync and edge
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			sync_q    <= 2'h0;
			soc_old_q <= 1'b0;
		end
		else
		begin
			sync_q    <= {sync_q[0], SOC_PIN};
			soc_old_q <= sync_q[1];
		end
	end

	// Start sources merged, pin may idle low
	assign start_ev = START_BIT || (sync_q[1] && !soc_old_q);

	////////////////////////////////////////////////////////////////////////
	// Sinc-like decimator, four staggered integrators
	// Conversion length picks resolution and rate
	always_comb
	begin
		tick_d   = tick_q;
		conv_end = 1'b0;
		for (int i = 0; i < dsq_pkg::DSQ_TAPS; i++)
			acc_d[i] = acc_q[i];
		if (st_q == dsq_pkg::DSQ_PRIME || st_q == dsq_pkg::DSQ_RUN)
		begin
			// Only the open window counts, closed ones stay frozen
			acc_d[dsq_pkg::DSQ_TAPS-1] = acc_q[dsq_pkg::DSQ_TAPS-1] + {7'h00, MOD_BIT};
			if (tick_q == osr_of(LOW_RES) - 8'h01)
			begin
				conv_end = 1'b1;
				tick_d   = 8'h00;
				// Oldest window drops, open one closes, fresh one opens
				for (int i = 0; i < dsq_pkg::DSQ_TAPS - 1; i++)
					acc_d[i] = acc_q[i+1];
				acc_d[dsq_pkg::DSQ_TAPS-2] = acc_q[dsq_pkg::DSQ_TAPS-1] + {7'h00, MOD_BIT};
				acc_d[dsq_pkg::DSQ_TAPS-1] = 8'h00;
				// Multi modes restart from empty windows
				if (st_q == dsq_pkg::DSQ_RUN && f_ready && mode_q != dsq_pkg::DSQ_SINGLE
					&& mode_q != dsq_pkg::DSQ_CONT)
					for (int i = 0; i < dsq_pkg::DSQ_TAPS; i++)
						acc_d[i] = 8'h00;
			end
			else
				tick_d = tick_q + 8'h01;
		end
		else
		begin
			tick_d = 8'h00;
			for (int i = 0; i < dsq_pkg::DSQ_TAPS; i++)
				acc_d[i] = 8'h00;
		end
	end

	// Three closed windows plus the one closing this cycle
	assign sum = {2'h0, acc_q[0]} + {2'h0, acc_q[1]} + {2'h0, acc_q[2]} + {2'h0, acc_q[3]}
		+ {9'h000, MOD_BIT};

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb
	begin
		st_d    = st_q;
		mode_d  = mode_q;
		prime_d = prime_q;
		push    = 1'b0;
		unique case (st_q)
			dsq_pkg::DSQ_IDLE:
			begin
				if (start_ev)
				begin
					mode_d  = dsq_pkg::dsq_mode_e'(MODE);
					prime_d = 2'h0;
					st_d    = dsq_pkg::DSQ_PRIME;
				end
			end
			dsq_pkg::DSQ_PRIME:
			begin
				// Three priming conversions, also for continuous
				if (conv_end)
				begin
					prime_d = prime_q + 2'h1;
					if (prime_q == dsq_pkg::DSQ_PRIME_CNT_W - 2'h1)
						st_d = dsq_pkg::DSQ_RUN;
				end
			end
			dsq_pkg::DSQ_RUN:
			begin
				if (conv_end && f_ready)
				begin
					push = 1'b1;
					if (mode_q == dsq_pkg::DSQ_CONT)
						st_d = STOP ? dsq_pkg::DSQ_IDLE : dsq_pkg::DSQ_RUN;
					else if (mode_q == dsq_pkg::DSQ_SINGLE)
						st_d = dsq_pkg::DSQ_HOLD;
					else
					begin
						// Reset and re-prime; no new start
						prime_d = 2'h0;
						st_d    = STOP ? dsq_pkg::DSQ_IDLE : dsq_pkg::DSQ_PRIME;
					end
				end
			end
			dsq_pkg::DSQ_HOLD:
			begin
				// Standby once the single result is taken
				if (f_valid && RESULT_READ && f_out.last)
					st_d = dsq_pkg::DSQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			st_q    <= dsq_pkg::DSQ_IDLE;
			mode_q  <= dsq_pkg::DSQ_SINGLE;
			prime_q <= 2'h0;
			tick_q  <= 8'h00;
			for (int i = 0; i < dsq_pkg::DSQ_TAPS; i++)
				acc_q[i] <= 8'h00;
		end
		else
		begin
			st_q    <= st_d;
			mode_q  <= mode_d;
			prime_q <= prime_d;
			tick_q  <= tick_d;
			for (int i = 0; i < dsq_pkg::DSQ_TAPS; i++)
				acc_q[i] <= acc_d[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Results wait here; full FIFO stalls the sequencer
	assign f_in.data = {6'h00, sum};
	assign f_in.last = (mode_q == dsq_pkg::DSQ_SINGLE);

	dsq_fifo #(
		.WIDTH ($bits(dsq_pkg::dsq_result_s)),
		.DEPTH (dsq_pkg::DSQ_FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst       (RST),
		.in_valid  (push),
		.in_ready  (f_ready),
		.in_data   (f_in),
		.out_valid (f_valid),
		.out_ready (RESULT_READ),
		.out_data  (f_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Done held until read; raised for every pushed result, not for priming conversions
	always_comb
	begin
		eoc_d = f_valid && !(RESULT_READ && eoc_q);
		// Result still in flight to the output register counts as pending
		if (push || (eoc_q && !f_valid))
			eoc_d = 1'b1;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			eoc_q  <= 1'b0;
			busy_q <= 1'b0;
			RESULT <= dsq_pkg::DSQ_RESULT_RST;
			RESULT_VALID <= 1'b0;
		end
		else
		begin
			eoc_q  <= eoc_d;
			busy_q <= (st_d != dsq_pkg::DSQ_IDLE);
			RESULT <= f_out.data;
			RESULT_VALID <= f_valid;
		end
	end

	assign EOC         = eoc_q;
	assign DONE_STATUS = eoc_q;
	assign BUSY        = busy_q;

	////////////////////////////////////////////////////////////////////////
	// Steps of a sample as named sequences
	sequence start_taken;
		st_q == dsq_pkg::DSQ_IDLE && start_ev;
	endsequence

	sequence last_prime;
		st_q == dsq_pkg::DSQ_PRIME && conv_end && prime_q == 2'h2;
	endsequence

	sequence single_taken;
		st_q == dsq_pkg::DSQ_HOLD && f_valid && RESULT_READ && f_out.last;
	endsequence

	soc_one_event_a: assert property (@(posedge CLK) disable iff (RST)
		(sync_q[1] && !soc_old_q) |=> !(sync_q[1] && !soc_old_q))
		else $error("start edge seen twice");
	start_prime_a: assert property (@(posedge CLK) disable iff (RST)
		start_taken |=> st_q == dsq_pkg::DSQ_PRIME)
		else $error("start did not begin priming");
	prime_to_run_a: assert property (@(posedge CLK) disable iff (RST)
		last_prime |=> st_q == dsq_pkg::DSQ_RUN)
		else $error("priming did not end after three");
	push_in_run_a: assert property (@(posedge CLK) disable iff (RST)
		push |-> (st_q == dsq_pkg::DSQ_RUN && prime_q == 2'h3))
		else $error("result pushed before priming");
	eoc_after_push_a: assert property (@(posedge CLK) disable iff (RST)
		push |=> EOC) else $error("done not raised");
	eoc_held_a: assert property (@(posedge CLK) disable iff (RST)
		(f_valid && !RESULT_READ) |=> EOC) else $error("done dropped before read");
	single_hold_a: assert property (@(posedge CLK) disable iff (RST)
		(st_q == dsq_pkg::DSQ_HOLD && !RESULT_READ) |=> st_q == dsq_pkg::DSQ_HOLD)
		else $error("single left hold before read");
	single_idle_a: assert property (@(posedge CLK) disable iff (RST)
		single_taken |=> st_q == dsq_pkg::DSQ_IDLE)
		else $error("single did not return to standby");
	multi_reprime_a: assert property (@(posedge CLK) disable iff (RST)
		(push && mode_q != dsq_pkg::DSQ_SINGLE && mode_q != dsq_pkg::DSQ_CONT && !STOP)
		|=> (st_q == dsq_pkg::DSQ_PRIME && acc_q[0] == 8'h00 && acc_q[1] == 8'h00
		&& acc_q[2] == 8'h00 && acc_q[3] == 8'h00))
		else $error("multi did not re-prime");
	cont_stays_a: assert property (@(posedge CLK) disable iff (RST)
		(push && mode_q == dsq_pkg::DSQ_CONT && !STOP) |=> st_q == dsq_pkg::DSQ_RUN)
		else $error("continuous left run");
	conv_len_a: assert property (@(posedge CLK) disable iff (RST)
		conv_end |-> tick_q == osr_of(LOW_RES) - 8'h01)
		else $error("conversion length wrong");
endmodule
`default_nettype wire

// File: hw/dsq_pkg.sv
// Package: shared constants, modes and carriers for the delta-sigma sequencer
// Assumes: single 10 MHz clock domain, no register bus
package dsq_pkg;

	// Operating modes, selected on a plain port
	typedef enum logic [1:0]
	{
		DSQ_SINGLE = 2'b00,
		DSQ_MULTI  = 2'b01,
		DSQ_CONT   = 2'b10,
		DSQ_TURBO  = 2'b11
	} dsq_mode_e;

	// Sequencer states
	typedef enum logic [1:0]
	{
		DSQ_IDLE  = 2'b00,
		DSQ_PRIME = 2'b01,
		DSQ_RUN   = 2'b10,
		DSQ_HOLD  = 2'b11
	} dsq_state_e;

	// Result carrier
	typedef struct packed
	{
		logic [15:0] data;
		logic        last;
	} dsq_result_s;

	localparam int          DSQ_RES_W       = 16;
	localparam int          DSQ_PRIME_CONV  = 3;
	localparam int          DSQ_TAPS        = 4;
	localparam logic [1:0]  DSQ_PRIME_CNT_W = 2'h3;
	localparam logic [15:0] DSQ_RESULT_RST  = 16'h0000;
	localparam logic [3:0]  DSQ_RES_12      = 4'hc;
	localparam logic [3:0]  DSQ_RES_8       = 4'h8;
	localparam int          DSQ_FIFO_DEPTH  = 8;
	// Oversampling ratio in clocks per conversion, default for 12 bits
	localparam int          DSQ_OSR_12      = 52;
	localparam int          DSQ_OSR_8       = 26;

endpackage

// File: hw/dsq_fifo.sv
// Holds: result FIFO with valid/ready on both sides
// Assumes: same clock on both sides, read data registered
`timescale 1ns/1ps
`default_nettype none
module dsq_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
)(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
	logic             ov_q, ov_d;
	logic [WIDTH-1:0] od_q, od_d;
	logic             wr, rd, cnt_empty;

	always_comb
	begin
		cnt_empty = (wp_q == rp_q);
		in_ready  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
		wr        = in_valid && in_ready;
		// Output register refills when empty or taken
		rd        = !cnt_empty && (!ov_q || out_ready);
		wp_d      = wr ? wp_q + 1'b1 : wp_q;
		rp_d      = rd ? rp_q + 1'b1 : rp_q;
		ov_d      = rd ? 1'b1 : (out_ready ? 1'b0 : ov_q);
		od_d      = rd ? mem_q[rp_q[AW-1:0]] : od_q;
	end

	always_ff @(posedge clk)
	begin
		if (wr)
			mem_q[wp_q[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wp_q <= '0;
			rp_q <= '0;
			ov_q <= 1'b0;
			od_q <= '0;
		end
		else
		begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			ov_q <= ov_d;
			od_q <= od_d;
		end
	end

	assign out_valid = ov_q;
	assign out_data  = od_q;

	// Full FIFO keeps its write pointer
	fifo_nofull_a: assert property (@(posedge clk) disable iff (rst)
		!in_ready |=> $stable(wp_q)) else $error("fifo written while full");
endmodule
`default_nettype wire

// File: verification/dsq_reader.sv
// Reader model: pops results as a CPU or DMA would
// Assumes: same clock as the sequencer
`timescale 1ns/1ps
`default_nettype none
module dsq_reader (
	input  wire logic        clk,
	input  wire logic        en,
	input  wire logic        slow,
	input  wire logic        valid,
	input  wire logic [15:0] data,
	output logic             read,
	output logic [15:0]      word,
	output int               cnt
);
	initial
	begin
		read = 1'b0;
		word = 16'h0000;
		cnt = 0;
		forever
		begin
			@(negedge clk);
			if (en && valid === 1'b1)
			begin
				repeat (slow ? 6 : 0) @(negedge clk);
				word = data;
				cnt++;
				read = 1'b1;
				@(negedge clk);
				read = 1'b0;
				// Result settles 1-2 cycles after a pop
				repeat (3) @(negedge clk);
			end
		end
	end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Testbench for the delta-sigma sequencer
// Assumes: short OSR parameters, reader model on the result side
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [1:0]  mode = 2'h0;
	logic        low_res = 1'b0;
	logic        start_bit = 1'b0;
	logic        stop = 1'b0;
	logic        soc_pin = 1'b0;
	logic        mod_bit = 1'b1;
	logic        rd_en = 1'b0;
	logic        slow = 1'b0;
	logic        result_read;
	logic [15:0] result;
	logic [15:0] word;
	logic        result_valid;
	logic        eoc;
	logic        done_status;
	logic        busy;
	int          cnt;
	int          cyc = 0;
	int          failures = 0;
	int          checks = 0;

	always #50 clk = ~clk;

	dsq_seq #(.OSR_HI(8), .OSR_LO(4)) i_dut (.CLK(clk), .RST(rst), .MODE(mode),
		.LOW_RES(low_res), .START_BIT(start_bit), .STOP(stop), .SOC_PIN(soc_pin),
		.MOD_BIT(mod_bit), .RESULT_READ(result_read), .RESULT(result),
		.RESULT_VALID(result_valid), .EOC(eoc), .DONE_STATUS(done_status), .BUSY(busy));

	dsq_reader i_rd (.clk(clk), .en(rd_en), .slow(slow), .valid(result_valid),
		.data(result), .read(result_read), .word(word), .cnt(cnt));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wait_eoc(output int n);
		n = 0;
		while (eoc !== 1'b1 && n < 1000)
		begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic pulse_start();
		start_bit = 1'b1;
		@(negedge clk);
		start_bit = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_single(input logic lr, input logic pin, input logic mb);
		int n;
		int c0;
		int o;
		o = lr ? 4 : 8;
		mode = dsq_pkg::DSQ_SINGLE;
		low_res = lr;
		mod_bit = mb;
		slow = 1'b1;
		// Pin driven as plain logic level
		if (pin)
			soc_pin = 1'b1;
		else
			pulse_start();
		repeat (o) @(negedge clk);
		pulse_start();
		wait_eoc(n);
		check(n + o + 2 >= 4 * o && n + o + 2 <= 4 * o + 6, 1'b1);
		repeat (2 * o) @(negedge clk);
		check({eoc, done_status, busy}, 3'h7);
		c0 = cnt;
		rd_en = 1'b1;
		repeat (12) @(negedge clk);
		rd_en = 1'b0;
		check(word, mb ? 16'(4 * o) : 16'h0000);
		check({eoc, done_status}, 2'h0);
		repeat (5 * o) @(negedge clk);
		check({result_valid, busy, 16'(cnt - c0)}, 18'h1);
		soc_pin = 1'b0;
		mod_bit = 1'b1;
		// Pin must sit low a while, else the next rise is no edge
		repeat (3) @(negedge clk);
	endtask

	task automatic t_run(input logic [1:0] m);
		int n;
		int t1;
		int gap;
		int e;
		mode = m;
		low_res = 1'b0;
		slow = 1'b0;
		rd_en = 1'b1;
		e = (m == dsq_pkg::DSQ_CONT) ? 8 : 32;
		pulse_start();
		wait_eoc(n);
		check(n + 1 >= 32 && n <= 40, 1'b1);
		t1 = cyc;
		repeat (3)
		begin
			while (eoc === 1'b1) @(negedge clk);
			wait_eoc(n);
			gap = cyc - t1;
			t1 = cyc;
			check(gap >= e - 2 && gap <= e + 3, 1'b1);
		end
		stop = 1'b1;
		repeat (80) @(negedge clk);
		check({busy, word}, {1'b0, 16'h0020});
		stop = 1'b0;
		rd_en = 1'b0;
	endtask

	task automatic t_fill();
		int c0;
		mode = dsq_pkg::DSQ_CONT;
		low_res = 1'b0;
		rd_en = 1'b0;
		pulse_start();
		repeat (20 * 8) @(negedge clk);
		check({result_valid, eoc}, 2'h3);
		stop = 1'b1;
		c0 = cnt;
		rd_en = 1'b1;
		repeat (200) @(negedge clk);
		check(cnt - c0 >= dsq_pkg::DSQ_FIFO_DEPTH, 1'b1);
		check({result_valid, busy}, 2'h0);
		stop = 1'b0;
		rd_en = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			print_verdict();
		end
	end

	initial
	begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		check({eoc, done_status, busy, result_valid}, 4'h0);
		t_single(1'b0, 1'b0, 1'b1);
		t_single(1'b1, 1'b1, 1'b1);
		t_single(1'b0, 1'b1, 1'b0);
		t_run(dsq_pkg::DSQ_CONT);
		t_run(dsq_pkg::DSQ_MULTI);
		t_run(dsq_pkg::DSQ_TURBO);
		t_fill();
		print_verdict();
	end
endmodule
`default_nettype wire
